// [gpw_gpio.sv]
// gpw_gpio: three-port gpio with pull-ups, port a wake and drive levels
// assumes: pins arrive asynchronously, register port on clk_sys, power_down from core
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module gpw_gpio (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        power_down,
  input  wire logic [7:0]  pa_in,
  output logic      [7:0]  pa_out,
  output logic      [7:0]  pa_oe,
  output logic      [7:0]  pa_pullup,
  output logic      [15:0] pa_level,
  input  wire logic [3:0]  pb_in,
  output logic      [3:0]  pb_out,
  output logic      [3:0]  pb_oe,
  output logic      [3:0]  pb_pullup,
  output logic      [7:0]  pb_level,
  input  wire logic [1:0]  pc_in,
  output logic      [1:0]  pc_out,
  output logic      [1:0]  pc_oe,
  output logic      [1:0]  pc_pullup,
  output logic      [3:0]  pc_level,
  output logic             wake_req,
  output logic             irq
);
  localparam int AW = gpw_pkg::PA_W;
  localparam int BW = gpw_pkg::PB_W;
  localparam int CW = gpw_pkg::PC_W;

  // ****************************************
  // register state
  // ****************************************
  logic [AW-1:0] a_data_ff, a_dir_ff, a_pu_ff, a_wake_ff, a_func_ff;
  logic [BW-1:0] b_data_ff, b_dir_ff, b_pu_ff, b_func_ff;
  logic [CW-1:0] c_data_ff, c_dir_ff, c_pu_ff, c_func_ff;
  logic [gpw_pkg::SEL_AB_W-1:0] sel_ab_ff;
  logic [gpw_pkg::SEL_C_W-1:0]  sel_c_ff;
  logic [gpw_pkg::IRQ_W-1:0]    irq_stat_ff, irq_mask_ff;
  logic [AW-1:0] nxt_a_data, nxt_a_dir, nxt_a_pu, nxt_a_wake, nxt_a_func;
  logic [BW-1:0] nxt_b_data, nxt_b_dir, nxt_b_pu, nxt_b_func;
  logic [CW-1:0] nxt_c_data, nxt_c_dir, nxt_c_pu, nxt_c_func;
  logic [gpw_pkg::SEL_AB_W-1:0] nxt_sel_ab;
  logic [gpw_pkg::SEL_C_W-1:0]  nxt_sel_c;
  logic [gpw_pkg::IRQ_W-1:0]    nxt_irq_stat, nxt_irq_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       wake_ff, nxt_wake, irq_ff, nxt_irq;
  logic [AW-1:0] a_prev_ff, nxt_a_prev;

  logic [AW-1:0] a_sync, a_read;
  logic [BW-1:0] b_sync, b_read;
  logic [CW-1:0] c_sync, c_read;
  logic          fall_any;

  // ****************************************
  // pin synchronisers and pad control
  // ****************************************
  gpw_sync #(.W(AW)) u_sync_a (.clk_sys(clk_sys), .reset_n(reset_n), .async_in(pa_in), .sync_out(a_sync));
  gpw_sync #(.W(BW)) u_sync_b (.clk_sys(clk_sys), .reset_n(reset_n), .async_in(pb_in), .sync_out(b_sync));
  gpw_sync #(.W(CW)) u_sync_c (.clk_sys(clk_sys), .reset_n(reset_n), .async_in(pc_in), .sync_out(c_sync));

  // port a splits into two halves with separate level codes
  gpw_pin_ctl #(.W(4)) u_ctl_a_lo (
    .clk_sys(clk_sys), .reset_n(reset_n), .data_latch(a_data_ff[3:0]), .dir_in(a_dir_ff[3:0]),
    .pullup_en(a_pu_ff[3:0]), .func_gpio(~a_func_ff[3:0]), .pin_sync(a_sync[3:0]),
    .level_sel(sel_ab_ff[gpw_pkg::FLD_PA_LO_LVL +: gpw_pkg::LVL_W]),
    .pad_out(pa_out[3:0]), .pad_oe(pa_oe[3:0]), .pad_pullup(pa_pullup[3:0]),
    .pad_level(pa_level[7:0]), .read_val(a_read[3:0]));
  gpw_pin_ctl #(.W(4)) u_ctl_a_hi (
    .clk_sys(clk_sys), .reset_n(reset_n), .data_latch(a_data_ff[7:4]), .dir_in(a_dir_ff[7:4]),
    .pullup_en(a_pu_ff[7:4]), .func_gpio(~a_func_ff[7:4]), .pin_sync(a_sync[7:4]),
    .level_sel(sel_ab_ff[gpw_pkg::FLD_PA_HI_LVL +: gpw_pkg::LVL_W]),
    .pad_out(pa_out[7:4]), .pad_oe(pa_oe[7:4]), .pad_pullup(pa_pullup[7:4]),
    .pad_level(pa_level[15:8]), .read_val(a_read[7:4]));
  gpw_pin_ctl #(.W(BW)) u_ctl_b (
    .clk_sys(clk_sys), .reset_n(reset_n), .data_latch(b_data_ff), .dir_in(b_dir_ff),
    .pullup_en(b_pu_ff), .func_gpio(~b_func_ff), .pin_sync(b_sync),
    .level_sel(sel_ab_ff[gpw_pkg::FLD_PB_LVL +: gpw_pkg::LVL_W]),
    .pad_out(pb_out), .pad_oe(pb_oe), .pad_pullup(pb_pullup),
    .pad_level(pb_level), .read_val(b_read));
  gpw_pin_ctl #(.W(CW)) u_ctl_c (
    .clk_sys(clk_sys), .reset_n(reset_n), .data_latch(c_data_ff), .dir_in(c_dir_ff),
    .pullup_en(c_pu_ff), .func_gpio(~c_func_ff), .pin_sync(c_sync),
    .level_sel(sel_c_ff[gpw_pkg::FLD_PC_LVL +: gpw_pkg::LVL_W]),
    .pad_out(pc_out), .pad_oe(pc_oe), .pad_pullup(pc_pullup),
    .pad_level(pc_level), .read_val(c_read));

  // ****************************************
  // wake detection
  // ****************************************
  // sampled history runs always, so the first powered-down cycle sees a true edge
  assign fall_any = |(a_prev_ff & ~a_sync & a_wake_ff & ~a_func_ff);

  always_comb begin
    nxt_a_prev = a_sync;
    nxt_wake = power_down & fall_any;
  end

  // ****************************************
  // register write and read
  // ****************************************
  always_comb begin
    nxt_a_data = a_data_ff;
    nxt_a_dir  = a_dir_ff;
    nxt_a_pu   = a_pu_ff;
    nxt_a_wake = a_wake_ff;
    nxt_a_func = a_func_ff;
    nxt_b_data = b_data_ff;
    nxt_b_dir  = b_dir_ff;
    nxt_b_pu   = b_pu_ff;
    nxt_b_func = b_func_ff;
    nxt_c_data = c_data_ff;
    nxt_c_dir  = c_dir_ff;
    nxt_c_pu   = c_pu_ff;
    nxt_c_func = c_func_ff;
    nxt_sel_ab = sel_ab_ff;
    nxt_sel_c  = sel_c_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_rdata = 8'h00;
    // unimplemented bits are dropped by the part-selects
    if (reg_wr) begin
      if (reg_addr == gpw_pkg::OFS_PORT_A_DATA) begin
        nxt_a_data = reg_wdata;
      end else if (reg_addr == gpw_pkg::OFS_PORT_A_DIRECTION) begin
        nxt_a_dir = reg_wdata;
      end else if (reg_addr == gpw_pkg::OFS_PORT_A_PULLUP) begin
        nxt_a_pu = reg_wdata;
      end else if (reg_addr == gpw_pkg::OFS_PORT_A_WAKE) begin
        nxt_a_wake = reg_wdata;
      end else if (reg_addr == gpw_pkg::OFS_PORT_B_DATA) begin
        nxt_b_data = reg_wdata[BW-1:0];
      end else if (reg_addr == gpw_pkg::OFS_PORT_B_DIRECTION) begin
        nxt_b_dir = reg_wdata[BW-1:0];
      end else if (reg_addr == gpw_pkg::OFS_PORT_B_PULLUP) begin
        nxt_b_pu = reg_wdata[BW-1:0];
      end else if (reg_addr == gpw_pkg::OFS_PORT_C_DATA) begin
        nxt_c_data = reg_wdata[CW-1:0];
      end else if (reg_addr == gpw_pkg::OFS_PORT_C_DIRECTION) begin
        nxt_c_dir = reg_wdata[CW-1:0];
      end else if (reg_addr == gpw_pkg::OFS_PORT_C_PULLUP) begin
        nxt_c_pu = reg_wdata[CW-1:0];
      end else if (reg_addr == gpw_pkg::OFS_DRIVE_SEL_AB) begin
        nxt_sel_ab = reg_wdata[gpw_pkg::SEL_AB_W-1:0];
      end else if (reg_addr == gpw_pkg::OFS_DRIVE_SEL_C) begin
        nxt_sel_c = reg_wdata[gpw_pkg::SEL_C_W-1:0];
      end else if (reg_addr == gpw_pkg::OFS_FUNC_SEL_A) begin
        nxt_a_func = reg_wdata;
      end else if (reg_addr == gpw_pkg::OFS_FUNC_SEL_B) begin
        nxt_b_func = reg_wdata[BW-1:0];
      end else if (reg_addr == gpw_pkg::OFS_FUNC_SEL_C) begin
        nxt_c_func = reg_wdata[CW-1:0];
      end else if (reg_addr == gpw_pkg::OFS_IRQ_STATUS) begin
        nxt_irq_stat = irq_stat_ff & ~reg_wdata[gpw_pkg::IRQ_W-1:0];
      end else if (reg_addr == gpw_pkg::OFS_IRQ_MASK) begin
        nxt_irq_mask = reg_wdata[gpw_pkg::IRQ_W-1:0];
      end
    end
    // set after clear: an edge in the clearing cycle survives
    if (nxt_wake) begin
      nxt_irq_stat[gpw_pkg::IRQ_BIT_WAKE] = 1'b1;
    end
    if (reg_rd) begin
      if (reg_addr == gpw_pkg::OFS_PORT_A_DATA) begin
        nxt_rdata = a_read;
      end else if (reg_addr == gpw_pkg::OFS_PORT_A_DIRECTION) begin
        nxt_rdata = a_dir_ff;
      end else if (reg_addr == gpw_pkg::OFS_PORT_A_PULLUP) begin
        nxt_rdata = a_pu_ff;
      end else if (reg_addr == gpw_pkg::OFS_PORT_A_WAKE) begin
        nxt_rdata = a_wake_ff;
      end else if (reg_addr == gpw_pkg::OFS_PORT_B_DATA) begin
        nxt_rdata = {4'h0, b_read};
      end else if (reg_addr == gpw_pkg::OFS_PORT_B_DIRECTION) begin
        nxt_rdata = {4'h0, b_dir_ff};
      end else if (reg_addr == gpw_pkg::OFS_PORT_B_PULLUP) begin
        nxt_rdata = {4'h0, b_pu_ff};
      end else if (reg_addr == gpw_pkg::OFS_PORT_C_DATA) begin
        nxt_rdata = {6'h00, c_read};
      end else if (reg_addr == gpw_pkg::OFS_PORT_C_DIRECTION) begin
        nxt_rdata = {6'h00, c_dir_ff};
      end else if (reg_addr == gpw_pkg::OFS_PORT_C_PULLUP) begin
        nxt_rdata = {6'h00, c_pu_ff};
      end else if (reg_addr == gpw_pkg::OFS_DRIVE_SEL_AB) begin
        nxt_rdata = {2'h0, sel_ab_ff};
      end else if (reg_addr == gpw_pkg::OFS_DRIVE_SEL_C) begin
        nxt_rdata = {6'h00, sel_c_ff};
      end else if (reg_addr == gpw_pkg::OFS_FUNC_SEL_A) begin
        nxt_rdata = a_func_ff;
      end else if (reg_addr == gpw_pkg::OFS_FUNC_SEL_B) begin
        nxt_rdata = {4'h0, b_func_ff};
      end else if (reg_addr == gpw_pkg::OFS_FUNC_SEL_C) begin
        nxt_rdata = {6'h00, c_func_ff};
      end else if (reg_addr == gpw_pkg::OFS_IRQ_STATUS) begin
        nxt_rdata = {7'h00, irq_stat_ff};
      end else if (reg_addr == gpw_pkg::OFS_IRQ_MASK) begin
        nxt_rdata = {7'h00, irq_mask_ff};
      end
    end
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      a_data_ff <= gpw_pkg::RST_DATA[AW-1:0];
      a_dir_ff  <= gpw_pkg::RST_DIR[AW-1:0];
      a_pu_ff   <= gpw_pkg::RST_PULLUP[AW-1:0];
      a_wake_ff <= gpw_pkg::RST_WAKE[AW-1:0];
      a_func_ff <= gpw_pkg::RST_FUNC[AW-1:0];
      b_data_ff <= gpw_pkg::RST_DATA[BW-1:0];
      b_dir_ff  <= gpw_pkg::RST_DIR[BW-1:0];
      b_pu_ff   <= gpw_pkg::RST_PULLUP[BW-1:0];
      b_func_ff <= gpw_pkg::RST_FUNC[BW-1:0];
      c_data_ff <= gpw_pkg::RST_DATA[CW-1:0];
      c_dir_ff  <= gpw_pkg::RST_DIR[CW-1:0];
      c_pu_ff   <= gpw_pkg::RST_PULLUP[CW-1:0];
      c_func_ff <= gpw_pkg::RST_FUNC[CW-1:0];
      sel_ab_ff <= gpw_pkg::RST_LEVEL[gpw_pkg::SEL_AB_W-1:0];
      sel_c_ff  <= gpw_pkg::RST_LEVEL[gpw_pkg::SEL_C_W-1:0];
      irq_stat_ff <= gpw_pkg::RST_IRQ[gpw_pkg::IRQ_W-1:0];
      irq_mask_ff <= gpw_pkg::RST_IRQ[gpw_pkg::IRQ_W-1:0];
      rdata_ff  <= 8'h00;
      wake_ff   <= 1'b0;
      irq_ff    <= 1'b0;
      a_prev_ff <= {AW{1'b1}};
    end else begin
      a_data_ff <= nxt_a_data;
      a_dir_ff  <= nxt_a_dir;
      a_pu_ff   <= nxt_a_pu;
      a_wake_ff <= nxt_a_wake;
      a_func_ff <= nxt_a_func;
      b_data_ff <= nxt_b_data;
      b_dir_ff  <= nxt_b_dir;
      b_pu_ff   <= nxt_b_pu;
      b_func_ff <= nxt_b_func;
      c_data_ff <= nxt_c_data;
      c_dir_ff  <= nxt_c_dir;
      c_pu_ff   <= nxt_c_pu;
      c_func_ff <= nxt_c_func;
      sel_ab_ff <= nxt_sel_ab;
      sel_c_ff  <= nxt_sel_c;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      rdata_ff  <= nxt_rdata;
      wake_ff   <= nxt_wake;
      irq_ff    <= nxt_irq;
      a_prev_ff <= nxt_a_prev;
    end
  end

  assign reg_rdata = rdata_ff;
  assign wake_req = wake_ff;
  assign irq = irq_ff;

  // ****************************************
  // checks
  // ****************************************
  sequence s_data_write;
    reg_wr && reg_addr == gpw_pkg::OFS_PORT_A_DATA;
  endsequence
  sequence s_no_data_write;
    !(reg_wr && reg_addr == gpw_pkg::OFS_PORT_A_DATA);
  endsequence

  AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_data_write ##1 s_no_data_write [*2] |-> pa_out == $past(reg_wdata, 2)) else $error("latch not held");
  AST_WAKE_EDGE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wake_req |-> $past(power_down) && $past(fall_any)) else $error("spurious wake");
  AST_WAKE_OFF_AWAKE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !$past(power_down) |-> !wake_req) else $error("wake while running");
  AST_WAKE_FIRES: assert property (@(posedge clk_sys) disable iff (!reset_n)
    power_down && fall_any |=> wake_req) else $error("missed wake edge");
  AST_PB_TOP_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && reg_addr == gpw_pkg::OFS_PORT_B_DIRECTION |=> reg_rdata[7:4] == 4'h0)
    else $error("unimplemented bits set");
  AST_STATUS_STICKY: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wake_req |-> irq_stat_ff[gpw_pkg::IRQ_BIT_WAKE]) else $error("status not set");
  AST_DIR_READBACK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_wr && reg_addr == gpw_pkg::OFS_PORT_C_DIRECTION ##2 reg_rd && reg_addr == gpw_pkg::OFS_PORT_C_DIRECTION
    |=> reg_rdata == {6'h00, $past(reg_wdata[1:0], 3)}) else $error("direction readback");
  AST_LEVEL_C: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pc_oe[0] |-> pc_level[1:0] == $past(sel_c_ff)) else $error("port c level");
endmodule

// [gpw_gpio_bench.sv]
// gpw_gpio_bench: self-checking bench for gpw_gpio against a register and pin model
// assumes: gpw_pkg compiled first, gpw_pins as the board
`timescale 1ns/1ps
module gpw_gpio_bench;
  logic        clk_sys, reset_n, reg_wr, reg_rd, power_down, wake_req, irq;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, pa_in, pa_out, pa_oe, pa_pullup, pb_level;
  logic [3:0]  pb_in, pb_out, pb_oe, pb_pullup, pc_level;
  logic [1:0]  pc_in, pc_out, pc_oe, pc_pullup;
  logic [15:0] pa_level;
  logic [13:0] ext_v, ext_e, e_out, e_oe, e_pu;
  logic [27:0] e_lv;
  logic [7:0]  mdl [0:31];
  logic [2:0]  wk [0:3];
  logic        seen;
  int          seed = 74;
  int          bad_count = 0;
  int          tests_run = 0;

  gpw_gpio gpw_gpio_inst (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down(power_down), .pa_in(pa_in),
    .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pullup), .pa_level(pa_level), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe(pb_oe), .pb_pullup(pb_pullup), .pb_level(pb_level), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
    .pc_pullup(pc_pullup), .pc_level(pc_level), .wake_req(wake_req), .irq(irq));
  gpw_pins #(.W(8)) gpw_pins_inst_a (.clk_sys(clk_sys), .pad_out(pa_out), .pad_oe(pa_oe), .pad_pullup(pa_pullup),
    .ext_val(ext_v[7:0]), .ext_en(ext_e[7:0]), .pin_lvl(pa_in));
  gpw_pins #(.W(4)) gpw_pins_inst_b (.clk_sys(clk_sys), .pad_out(pb_out), .pad_oe(pb_oe), .pad_pullup(pb_pullup),
    .ext_val(ext_v[11:8]), .ext_en(ext_e[11:8]), .pin_lvl(pb_in));
  gpw_pins #(.W(2)) gpw_pins_inst_c (.clk_sys(clk_sys), .pad_out(pc_out), .pad_oe(pc_oe), .pad_pullup(pc_pullup),
    .ext_val(ext_v[13:12]), .ext_en(ext_e[13:12]), .pin_lvl(pc_in));

  // ****************************************
  // model
  // ****************************************
  function automatic logic [7:0] msk(input int a);
    case (a)
      0, 1, 2, 3, 16: msk = 8'hFF;
      4, 5, 6, 17: msk = 8'h0F;
      8, 9, 10, 13, 18: msk = 8'h03;
      12: msk = 8'h3F;
      20, 21: msk = 8'h01;
      default: msk = 8'h00;
    endcase
  endfunction

  // data reads: latch where output, live pin where input
  function automatic logic [7:0] expr(input int a);
    logic [7:0] pin;
    pin = 8'(ext_v >> ((a == 0) ? 0 : 4 + a));
    if (a < 12 && a % 4 == 0) expr = ((mdl[a] & ~mdl[a+1]) | (pin & mdl[a+1])) & msk(a);
    else expr = mdl[a] & msk(a);
  endfunction

  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input int a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= 5'(a);
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == 20) mdl[a] = mdl[a] & ~d;
    else mdl[a] = d & msk(a);
  endtask

  task automatic rd(input int a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= 5'(a);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", {20'h0, expr(a)}, {20'h0, reg_rdata});
  endtask

  task automatic pads();
    int p, b;
    logic [1:0] cd;
    for (int j = 0; j < 14; j++) begin
      p = (j < 8) ? 0 : ((j < 12) ? 1 : 2);
      b = j - ((p == 0) ? 0 : 4 + 4 * p);
      cd = (j < 4) ? mdl[12][1:0] : (j < 8) ? mdl[12][3:2] : (j < 12) ? mdl[12][5:4] : mdl[13][1:0];
      e_out[j] = mdl[4*p][b];
      e_oe[j] = ~mdl[4*p+1][b] & ~mdl[16+p][b];
      e_pu[j] = mdl[4*p+2][b] & mdl[4*p+1][b] & ~mdl[16+p][b];
      e_lv[2*j +: 2] = e_oe[j] ? cd : 2'h0;
    end
    chk("out", 28'(e_out), 28'({pc_out, pb_out, pa_out}));
    chk("oe", 28'(e_oe), 28'({pc_oe, pb_oe, pa_oe}));
    chk("pullup", 28'(e_pu), 28'({pc_pullup, pb_pullup, pa_pullup}));
    chk("level", e_lv, {pc_level, pb_level, pa_level});
  endtask

  task automatic summarize();
    $display("checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  initial begin
    {reset_n, reg_wr, reg_rd, power_down, reg_addr, reg_wdata} = '0;
    ext_v = '1;
    ext_e = '1;
    wk = '{3'b111, 3'b110, 3'b011, 3'b101};
    for (int a = 0; a < 32; a++) mdl[a] = 8'h00;
    for (int a = 0; a < 10; a++) if (a % 4 < 2) mdl[a] = gpw_pkg::RST_DATA & msk(a);
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pads();
    for (int a = 0; a < 32; a++) rd(a);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      ext_v <= 14'($random(seed));
      ext_e <= 14'($random(seed));
      for (int a = 0; a < 32; a++) wr(a, 8'($random(seed)));
      repeat (4) @(posedge clk_sys);
      pads();
      ext_e <= '1;
      repeat (4) @(posedge clk_sys);
      for (int a = 0; a < 32; a++) rd(a);
      wr(9, 8'($random(seed)));
      rd(9);
    end
    $display("test register map and pads done");
    // cases: power_down, wake enabled, irq mask
    for (int k = 0; k < 4; k++) begin
      wr(1, 8'hFF);
      wr(16, 8'h00);
      wr(3, wk[k][1] ? 8'h08 : 8'hF7);
      wr(21, {7'h0, wk[k][0]});
      ext_v[7:0] <= 8'hFF;
      repeat (6) @(posedge clk_sys);
      power_down <= wk[k][2];
      @(posedge clk_sys);
      ext_v[3] <= 1'b0;
      seen = 1'b0;
      repeat (10) begin
        @(posedge clk_sys);
        #1;
        if (wake_req === 1'b1) seen = 1'b1;
      end
      chk("wake_req", 28'(wk[k][2] & wk[k][1]), 28'(seen));
      chk("irq", 28'(&wk[k]), 28'(irq));
      if (wk[k][2] & wk[k][1]) mdl[20] = 8'h01;
      rd(20);
      power_down <= 1'b0;
      wr(20, 8'h01);
      rd(20);
      @(posedge clk_sys);
      #1;
      chk("irq", 28'h0, 28'(irq));
    end
    $display("test wake and irq done");
    summarize();
  end
endmodule

// [gpw_pin_ctl.sv]
// gpw_pin_ctl: per-port pad control from data, direction, pull-up and level settings
// assumes: func_gpio high where the pin is given to general purpose io
`timescale 1ns/1ps
module gpw_pin_ctl #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] data_latch,
  input  wire logic [W-1:0] dir_in,
  input  wire logic [W-1:0] pullup_en,
  input  wire logic [W-1:0] func_gpio,
  input  wire logic [W-1:0] pin_sync,
  input  wire logic [1:0]   level_sel,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe,
  output logic      [W-1:0] pad_pullup,
  output logic      [W*2-1:0] pad_level,
  output logic      [W-1:0] read_val
);
  logic [W-1:0]   nxt_out;
  logic [W-1:0]   nxt_oe;
  logic [W-1:0]   nxt_pu;
  logic [W*2-1:0] nxt_lvl;
  logic [W-1:0]   out_ff;
  logic [W-1:0]   oe_ff;
  logic [W-1:0]   pu_ff;
  logic [W*2-1:0] lvl_ff;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_out[i] = data_latch[i];
      nxt_oe[i] = func_gpio[i] & ~dir_in[i];
      // pull-up only on a gpio input; alt functions count as driven here
      nxt_pu[i] = pullup_en[i] & func_gpio[i] & dir_in[i];
      // level code only reaches a push-pull output
      nxt_lvl[i*2 +: 2] = nxt_oe[i] ? level_sel : 2'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_ff <= {W{1'b1}};
      oe_ff  <= {W{1'b0}};
      pu_ff  <= {W{1'b0}};
      lvl_ff <= {(W*2){1'b0}};
    end else begin
      out_ff <= nxt_out;
      oe_ff  <= nxt_oe;
      pu_ff  <= nxt_pu;
      lvl_ff <= nxt_lvl;
    end
  end

  // outputs read the latch, inputs the live synchronised pin
  assign read_val = (~dir_in & data_latch) | (dir_in & pin_sync);
  assign pad_out = out_ff;
  assign pad_oe = oe_ff;
  assign pad_pullup = pu_ff;
  assign pad_level = lvl_ff;

  AST_OE_FOLLOWS_DIR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1 |=> pad_oe == ($past(func_gpio) & ~$past(dir_in))) else $error("pad enable wrong");
  AST_PULLUP_GATED: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1 |=> (pad_pullup & ~$past(dir_in)) == '0) else $error("pull-up on an output");
  AST_LATCH_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ((read_val ^ data_latch) & ~dir_in) == '0) else $error("output read not latch");
endmodule

// [gpw_pins.sv]
// gpw_pins: board-side model of one port's pins, a switch or load per pin
// assumes: pad controls from gpw_gpio, ext_en high where the board drives the pin
`timescale 1ns/1ps
module gpw_pins #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] pad_oe,
  input  wire logic [W-1:0] pad_pullup,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin_lvl
);
  // ****************************************
  // pin level
  // ****************************************
  // an undriven pin without pull-up floats: toggle so stale values never pass
  logic [W-1:0] flt_ff = '0;
  always_ff @(posedge clk_sys) begin
    flt_ff <= ~flt_ff;
  end
  assign pin_lvl = (pad_oe & pad_out)
                 | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & pad_pullup)
                 | (~pad_oe & ~ext_en & ~pad_pullup & flt_ff);
endmodule

// [gpw_pkg.sv]
// gpw_pkg: register map, reset values and field layout of the three-port gpio block
// assumes: 8-bit register port, byte-indexed offsets chosen locally
package gpw_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [4:0] OFS_PORT_A_DATA      = 5'h00;
  localparam logic [4:0] OFS_PORT_A_DIRECTION = 5'h01;
  localparam logic [4:0] OFS_PORT_A_PULLUP    = 5'h02;
  localparam logic [4:0] OFS_PORT_A_WAKE      = 5'h03;
  localparam logic [4:0] OFS_PORT_B_DATA      = 5'h04;
  localparam logic [4:0] OFS_PORT_B_DIRECTION = 5'h05;
  localparam logic [4:0] OFS_PORT_B_PULLUP    = 5'h06;
  localparam logic [4:0] OFS_PORT_C_DATA      = 5'h08;
  localparam logic [4:0] OFS_PORT_C_DIRECTION = 5'h09;
  localparam logic [4:0] OFS_PORT_C_PULLUP    = 5'h0A;
  localparam logic [4:0] OFS_DRIVE_SEL_AB     = 5'h0C;
  localparam logic [4:0] OFS_DRIVE_SEL_C      = 5'h0D;
  localparam logic [4:0] OFS_FUNC_SEL_A       = 5'h10;
  localparam logic [4:0] OFS_FUNC_SEL_B       = 5'h11;
  localparam logic [4:0] OFS_FUNC_SEL_C       = 5'h12;
  localparam logic [4:0] OFS_IRQ_STATUS       = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK         = 5'h15;
  // ****************************************
  // widths and field layout
  // ****************************************
  localparam int PA_W = 8;
  localparam int PB_W = 4;
  localparam int PC_W = 2;
  localparam int LVL_W = 2;
  localparam int SEL_AB_W = 6;
  localparam int SEL_C_W = 2;
  localparam int FLD_PB_LVL = 4;
  localparam int FLD_PA_HI_LVL = 2;
  localparam int FLD_PA_LO_LVL = 0;
  localparam int FLD_PC_LVL = 0;
  localparam int IRQ_W = 1;
  localparam int IRQ_BIT_WAKE = 0;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_DATA   = 8'hFF;
  localparam logic [7:0] RST_DIR    = 8'hFF;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_WAKE   = 8'h00;
  localparam logic [7:0] RST_LEVEL  = 8'h00;
  localparam logic [7:0] RST_FUNC   = 8'h00;
  localparam logic [7:0] RST_IRQ    = 8'h00;
endpackage

// [gpw_sync.sv]
// gpw_sync: two-flop synchroniser for a vector of pin levels
// assumes: inputs asynchronous to clk_sys
`timescale 1ns/1ps
module gpw_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // resets high so a pulled-up pin does not look like a falling edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule
